/* File: rtl/sspr_relay.sv */
/*
 * Serial packet relay of a stackable monitor: host port, vertical link
 * relay north and south, packet framing, crc generation and checking.
 * Assumes a 20 MHz clk that oversamples the serial clock (400 ns period)
 * and a register file outside that answers readByte for readOffset.
 */
`timescale 1ns/1ps
module sspr_relay (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // configuration and strap
    input  wire logic                isBase,
    input  wire logic [5:0]          deviceAddr,
    input  wire logic                check_byte_disable,
    // host port
    input  wire logic                hostSelect_n,
    input  wire logic                hostSclk,
    input  wire logic                host_serial_in,
    output logic                     host_serial_out,
    output logic                     hostAlert,
    // south side of the vertical link
    input  wire sspr_pkg::sspr_link_t southIn,
    output sspr_pkg::sspr_link_t     southOut,
    // north side of the vertical link
    input  wire sspr_pkg::sspr_link_t northIn,
    output sspr_pkg::sspr_link_t     northOut,
    // register file side
    output logic [7:0]               readOffset,
    input  wire logic [7:0]          readByte,
    output logic                     writeStrobe,
    output sspr_pkg::sspr_write_t    writeData,
    input  wire logic                faultClear,
    output logic                     crcFault,
    output logic                     linkActive
);
    import sspr_pkg::*;

    // ========================================================
    // input synchronisers: two flops before any logic looks
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    assign rawIn = {~hostSelect_n, hostSclk, host_serial_in,
                    southIn.select, southIn.sclk, southIn.sdi,
                    northIn.sdo, southIn.convStart, northIn.dataReady,
                    northIn.alert};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {syncB, syncA} <= '0;
        end else begin
            {syncB, syncA} <= {syncA, rawIn};
        end
    end

    // pick host or south side depending on base strap
    logic selIn, sclkIn, sdiIn;
    logic nSdo, sConv, nDrdy, nAlert;
    assign selIn  = isBase ? syncB[9] : syncB[6];
    assign sclkIn = isBase ? syncB[8] : syncB[5];
    assign sdiIn  = isBase ? syncB[7] : syncB[4];
    assign nSdo   = syncB[3];
    assign sConv  = syncB[2];
    assign nDrdy  = syncB[1];
    assign nAlert = syncB[0];

    // ========================================================
    // edge detection on the sampled serial clock and select
    logic sclkPrev_reg, selPrev_reg;
    logic sclkRise, sclkFall, selRise, selFall;
    assign sclkRise = sclkIn & ~sclkPrev_reg;
    assign sclkFall = ~sclkIn & sclkPrev_reg;
    assign selRise  = selIn & ~selPrev_reg;
    assign selFall  = ~selIn & selPrev_reg;

    // ========================================================
    // packet receiver state
    sspr_state_t state_reg, state_next;
    logic [2:0]  bitCnt_reg, bitCnt_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  crc_reg, crc_next;
    logic [7:0]  len_reg, len_next;
    logic [7:0]  offs_reg, offs_next;
    logic [5:0]  addr_reg, addr_next;
    logic        isWrite_reg, isWrite_next;
    logic        hit_reg, hit_next;
    logic [7:0]  txByte_reg, txByte_next;
    logic        txOn_reg, txOn_next;
    logic        txBit_reg, txBit_next;
    sspr_write_t wbuf_reg, wbuf_next;
    logic [2:0]  wrBytes_reg, wrBytes_next;
    logic        fault_reg, fault_next;
    logic        strobe_reg, strobe_next;

    logic [7:0]  crcStep;
    logic [7:0]  byteIn;
    logic        addrValid;
    logic        crcTx;
    assign byteIn    = {shift_reg[6:0], sdiIn};
    assign addrValid = deviceAddr != SSPR_ADDR_NONE;

    // crc over received bit, or over transmitted bit while replying
    sspr_crc8_step uCrc (.crcIn(crc_reg), .bitIn(crcTx), .crcOut(crcStep));
    assign crcTx = (state_reg == SSPR_ST_RDAT) ? txByte_reg[7] : sdiIn;

    // next-state logic for the receiver and reply shifter
    always_comb begin
        state_next   = state_reg;
        bitCnt_next  = bitCnt_reg;
        shift_next   = shift_reg;
        crc_next     = crc_reg;
        len_next     = len_reg;
        offs_next    = offs_reg;
        addr_next    = addr_reg;
        isWrite_next = isWrite_reg;
        hit_next     = hit_reg;
        txByte_next  = txByte_reg;
        txOn_next    = txOn_reg;
        txBit_next   = txBit_reg;
        wbuf_next    = wbuf_reg;
        wrBytes_next = wrBytes_reg;
        fault_next   = fault_reg;
        strobe_next  = 1'b0;
        // clear first: a fault set further down in this cycle wins
        if (faultClear) begin
            fault_next = 1'b0;
        end
        if (selRise) begin
            // select assertion resynchronises the receiver
            state_next   = SSPR_ST_ADDR;
            bitCnt_next  = '0;
            shift_next   = SSPR_BYTE_RESET;
            crc_next     = SSPR_CRC_INIT;
            len_next     = SSPR_LEN_RESET;
            hit_next     = 1'b0;
            txOn_next    = 1'b0;
            txBit_next   = 1'b0;
            wrBytes_next = '0;
        end else if (selFall) begin
            txOn_next  = 1'b0;
            txBit_next = 1'b0;
            if (hit_reg && isWrite_reg) begin
                if (check_byte_disable) begin
                    strobe_next = wrBytes_reg == SSPR_WR_BYTES_RAW;
                end else if (wrBytes_reg == SSPR_WR_BYTES_CRC
                             && crc_reg == SSPR_CRC_INIT) begin
                    strobe_next = 1'b1;
                    fault_next  = 1'b0;
                end else begin
                    fault_next  = 1'b1;
                end
            end
            state_next = SSPR_ST_DONE;
        end else if (selIn && sclkRise && txOn_reg) begin
            // mode 1: present next reply bit on the rising edge
            txBit_next = txByte_reg[7];
        end else if (selIn && sclkFall) begin
            shift_next  = byteIn;
            bitCnt_next = bitCnt_reg + 3'h1;
            if (state_reg != SSPR_ST_RCRC && state_reg != SSPR_ST_DONE) begin
                crc_next = crcStep;
            end
            if (state_reg == SSPR_ST_RDAT || state_reg == SSPR_ST_RCRC) begin
                txByte_next = {txByte_reg[6:0], 1'b0};
            end
            if (bitCnt_reg == SSPR_BIT_LAST) begin
                if (isWrite_reg && hit_reg) begin
                    wrBytes_next = wrBytes_reg + 3'h1;
                end
                case (state_reg)
                    SSPR_ST_ADDR: begin
                        addr_next    = byteIn[SSPR_ADDR_MSB:SSPR_ADDR_LSB];
                        isWrite_next = byteIn[SSPR_RW_BIT];
                        hit_next     = addrValid &&
                            (byteIn[SSPR_ADDR_MSB:SSPR_ADDR_LSB] == deviceAddr
                             || (byteIn[SSPR_RW_BIT] &&
                                 byteIn[SSPR_ADDR_MSB:SSPR_ADDR_LSB]
                                 == SSPR_ADDR_BCAST));
                        wrBytes_next = {2'b00, byteIn[SSPR_RW_BIT]};
                        state_next   = SSPR_ST_OFFS;
                    end
                    SSPR_ST_OFFS: begin
                        offs_next  = byteIn;
                        state_next = isWrite_reg ? SSPR_ST_WDAT
                                                 : SSPR_ST_LEN;
                    end
                    SSPR_ST_LEN: begin
                        len_next    = byteIn;
                        txByte_next = readByte;
                        txOn_next   = hit_reg;
                        state_next  = (byteIn == SSPR_LEN_RESET)
                                      ? SSPR_ST_RCRC : SSPR_ST_RDAT;
                        if (byteIn == SSPR_LEN_RESET) begin
                            txByte_next = crcStep;
                            txOn_next   = hit_reg && !check_byte_disable;
                        end
                    end
                    SSPR_ST_WDAT: begin
                        wbuf_next  = '{addr: addr_reg, offset: offs_reg,
                                       data: byteIn};
                        state_next = SSPR_ST_WCRC;
                    end
                    SSPR_ST_RDAT: begin
                        len_next  = len_reg - 8'h01;
                        offs_next = offs_reg + 8'h01;
                        if (len_reg == 8'h01) begin
                            state_next  = SSPR_ST_RCRC;
                            txByte_next = crcStep;
                            txOn_next   = hit_reg && !check_byte_disable;
                        end else begin
                            txByte_next = readByte;
                        end
                    end
                    SSPR_ST_RCRC: begin
                        state_next = SSPR_ST_DONE;
                        txOn_next  = 1'b0;
                    end
                    default: begin
                        state_next = state_reg;
                    end
                endcase
            end
        end
        // select not held: keep the link in its low-power idle
        if (!selIn) begin
            txOn_next  = 1'b0;
            txBit_next = 1'b0;
        end
    end

    // offset requested from the register file for the next reply byte
    logic [7:0] rdOffs;
    assign rdOffs = (state_reg == SSPR_ST_LEN) ? offs_reg
                                               : offs_reg + 8'h01;

    // receiver and reply registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclkPrev_reg <= 1'b0;
            selPrev_reg  <= 1'b0;
            state_reg    <= SSPR_ST_DONE;
            bitCnt_reg   <= '0;
            shift_reg    <= SSPR_BYTE_RESET;
            crc_reg      <= SSPR_CRC_INIT;
            len_reg      <= SSPR_LEN_RESET;
            offs_reg     <= SSPR_BYTE_RESET;
            addr_reg     <= SSPR_ADDR_NONE;
            isWrite_reg  <= 1'b0;
            hit_reg      <= 1'b0;
            txByte_reg   <= SSPR_BYTE_RESET;
            txOn_reg     <= 1'b0;
            txBit_reg    <= 1'b0;
            wbuf_reg     <= '0;
            wrBytes_reg  <= '0;
            fault_reg    <= 1'b0;
            strobe_reg   <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkIn;
            selPrev_reg  <= selIn;
            state_reg    <= state_next;
            bitCnt_reg   <= bitCnt_next;
            shift_reg    <= shift_next;
            crc_reg      <= crc_next;
            len_reg      <= len_next;
            offs_reg     <= offs_next;
            addr_reg     <= addr_next;
            isWrite_reg  <= isWrite_next;
            hit_reg      <= hit_next;
            txByte_reg   <= txByte_next;
            txOn_reg     <= txOn_next;
            txBit_reg    <= txBit_next;
            wbuf_reg     <= wbuf_next;
            wrBytes_reg  <= wrBytes_next;
            fault_reg    <= fault_next;
            strobe_reg   <= strobe_next;
        end
    end

    // ========================================================
    // relay outputs, all registered
    logic       hostOut_next, hostAlert_next;
    sspr_link_t south_next, north_next;
    always_comb begin
        // reply leaves southward; relayed data from above joins it
        south_next           = '0;
        south_next.sdo       = !isBase && (txBit_reg | nSdo);
        south_next.dataReady = nDrdy;
        south_next.alert     = !isBase && (fault_reg | nAlert);
        hostOut_next         = isBase && (txBit_reg | nSdo);
        hostAlert_next       = isBase && (fault_reg | nAlert);
        // upward: select active high, clock and data gated by select
        north_next           = '0;
        north_next.select    = selIn && addrValid;
        north_next.sclk      = selIn && sclkIn;
        north_next.sdi       = selIn && sdiIn;
        north_next.convStart = sConv;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_serial_out <= 1'b0;
            hostAlert       <= 1'b0;
            southOut        <= '0;
            northOut        <= '0;
            readOffset      <= SSPR_BYTE_RESET;
            writeStrobe     <= 1'b0;
            writeData       <= '0;
            crcFault        <= 1'b0;
            linkActive      <= 1'b0;
        end else begin
            host_serial_out <= hostOut_next;
            hostAlert       <= hostAlert_next;
            southOut        <= south_next;
            northOut        <= north_next;
            readOffset      <= rdOffs;
            writeStrobe <= strobe_reg;
            writeData   <= wbuf_reg;
            crcFault    <= fault_reg;
            linkActive  <= selIn;
        end
    end
endmodule

/* File: include/sspr_pkg.sv */
/*
 * Package for the stacked serial packet relay: packet layout constants,
 * address encodings, crc polynomial, receiver states and packed carriers.
 * Assumes a single 20 MHz system clock samples all serial pins.
 */
package sspr_pkg;

    // ========================================================
    // packet layout
    localparam logic [5:0] SSPR_ADDR_BCAST   = 6'h3F;
    localparam logic [5:0] SSPR_ADDR_NONE    = 6'h00;
    localparam int         SSPR_ADDR_MSB     = 6;
    localparam int         SSPR_ADDR_LSB     = 1;
    localparam int         SSPR_RW_BIT       = 0;
    localparam logic [7:0] SSPR_CRC_POLY     = 8'h07;
    localparam logic [7:0] SSPR_CRC_INIT     = 8'h00;
    localparam logic [7:0] SSPR_BYTE_RESET   = 8'h00;
    localparam logic [2:0] SSPR_BIT_LAST     = 3'h7;
    localparam logic [7:0] SSPR_LEN_RESET    = 8'h00;
    // write packet byte count with and without trailing check byte
    localparam logic [2:0] SSPR_WR_BYTES_CRC = 3'h4;
    localparam logic [2:0] SSPR_WR_BYTES_RAW = 3'h3;

    // ========================================================
    // receiver states
    typedef enum logic [2:0] {
        SSPR_ST_ADDR = 3'b000,
        SSPR_ST_OFFS = 3'b001,
        SSPR_ST_LEN  = 3'b010,
        SSPR_ST_WDAT = 3'b011,
        SSPR_ST_WCRC = 3'b100,
        SSPR_ST_RDAT = 3'b101,
        SSPR_ST_RCRC = 3'b110,
        SSPR_ST_DONE = 3'b111
    } sspr_state_t;

    // ========================================================
    // carriers
    typedef struct packed {
        logic       select;
        logic       sclk;
        logic       sdi;
        logic       sdo;
        logic       convStart;
        logic       dataReady;
        logic       alert;
    } sspr_link_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] offset;
        logic [7:0] data;
    } sspr_write_t;

endpackage

/* File: rtl/sspr_crc8_step.sv */
/*
 * One-bit step of the packet crc-8 (x^8+x^2+x+1), msb first.
 * Assumes the caller holds the crc register and resets it per packet.
 */
`timescale 1ns/1ps
module sspr_crc8_step (
    // crc in and out
    input  wire logic [7:0] crcIn,
    input  wire logic       bitIn,
    output logic      [7:0] crcOut
);
    import sspr_pkg::*;

    // shift left, fold the polynomial when msb and input differ
    always_comb begin
        if (crcIn[7] ^ bitIn) begin
            crcOut = {crcIn[6:0], 1'b0} ^ SSPR_CRC_POLY;
        end else begin
            crcOut = {crcIn[6:0], 1'b0};
        end
    end
endmodule

/* File: testbench/sspr_relay_props.sv */
/*
 * Checker for the stacked serial packet relay, bound to sspr_relay.
 * Assumes a 20 MHz clk and a serial clock of eight clk or slower.
 */
`timescale 1ns/1ps
module sspr_relay_props (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // strap and host port
    input wire logic                 isBase,
    input wire logic [5:0]           deviceAddr,
    input wire logic                 hostSelect_n,
    input wire logic                 hostSclk,
    input wire logic                 host_serial_in,
    input wire logic                 host_serial_out,
    input wire logic                 hostAlert,
    // vertical link
    input wire sspr_pkg::sspr_link_t northIn,
    input wire sspr_pkg::sspr_link_t southOut,
    input wire sspr_pkg::sspr_link_t northOut,
    // register side
    input wire logic                 writeStrobe,
    input wire logic                 faultClear,
    input wire logic                 crcFault
);
    import sspr_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // a selected frame on an addressed base device
    sequence framed;
        !hostSelect_n && isBase && deviceAddr != SSPR_ADDR_NONE;
    endsequence

    // ==========================================================
    // select, clock and data relay north; six clk covers the sync
    selAssert_a: assert property (
        $fell(hostSelect_n) ##0 framed |-> ##[1:6] northOut.select)
        else $error("link select missed host select");
    selRelease_a: assert property (
        $rose(hostSelect_n) |-> ##[1:6] !northOut.select)
        else $error("link select held after release");
    selZero_a: assert property (
        (deviceAddr == SSPR_ADDR_NONE) [*3] |-> !northOut.select)
        else $error("select passed north without address");
    idleLow_a: assert property (
        hostSelect_n [*8] |-> !northOut.select && !northOut.sclk
            && !northOut.sdi && !host_serial_out)
        else $error("link not idle low");
    sclkFollow_a: assert property (
        framed ##0 $rose(hostSclk) |-> ##[1:6] northOut.sclk)
        else $error("serial clock not relayed");
    sdiFollow_a: assert property (
        framed ##0 $rose(host_serial_in) |-> ##[1:6] northOut.sdi)
        else $error("write data not relayed north");
    noSouth_a: assert property (isBase |-> !southOut.sdo)
        else $error("base drives south data");

    // ==========================================================
    // fault, alert and commit
    alertDown_a: assert property (
        (isBase && (crcFault || northIn.alert)) [*6] |-> hostAlert)
        else $error("alert not passed to host");
    strobeEnd_a: assert property (
        writeStrobe |-> hostSelect_n ##1 !writeStrobe)
        else $error("commit not a pulse after release");
    faultHold_a: assert property (
        crcFault && !faultClear && !$past(faultClear) && !hostSelect_n
            |=> crcFault)
        else $error("fault lost during frame");
    faultClr_a: assert property (
        faultClear && !hostSelect_n |-> ##2 !crcFault)
        else $error("fault not cleared");
    readyDown_a: assert property (
        $rose(northIn.dataReady) |-> ##[1:6] southOut.dataReady)
        else $error("data ready not relayed");
endmodule

bind sspr_relay sspr_relay_props props (
    .clk, .rst_n, .isBase, .deviceAddr, .hostSelect_n, .hostSclk,
    .host_serial_in, .host_serial_out, .hostAlert, .northIn,
    .southOut, .northOut, .writeStrobe, .faultClear, .crcFault
);

/* File: testbench/sspr_host_model.sv */
/*
 * Host controller model: shifts whole packets in serial mode 1.
 * Assumes frame is entered just after a rising edge of clk.
 */
`timescale 1ns/1ps
module sspr_host_model (
    // clock
    input wire logic clk,
    // host pins
    output logic     hostSelect_n,
    output logic     hostSclk,
    output logic     host_serial_in,
    input wire logic host_serial_out
);
    // idle with select high, clock and data low to save power
    initial begin
        hostSelect_n = 1'b1;
        hostSclk = 1'b0;
        host_serial_in = 1'b0;
    end

    // ==========================================================
    // one packet: data set on rise, reply taken a full period later
    task automatic frame(input logic [7:0] tx[8], input int n,
                         output logic [7:0] rx[8]);
        hostSelect_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) begin
                hostSclk <= 1'b1;
                host_serial_in <= tx[i][k];
                repeat (4) @(posedge clk);
                hostSclk <= 1'b0;
                repeat (4) @(posedge clk);
                rx[i][k] = host_serial_out;
            end
        end
        hostSelect_n <= 1'b1;
        host_serial_in <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
endmodule

/* File: testbench/testbench.sv */
/*
 * Self-checking bench for sspr_relay as a base device.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
module testbench;
    import sspr_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n;
    logic [5:0]  deviceAddr;
    logic        check_byte_disable;
    logic        hostSelect_n;
    logic        hostSclk;
    logic        host_serial_in;
    logic        host_serial_out;
    logic        hostAlert;
    sspr_link_t  northIn;
    sspr_link_t  southOut;
    sspr_link_t  northOut;
    logic [7:0]  readOffset;
    logic [7:0]  readByte;
    logic        writeStrobe;
    sspr_write_t writeData;
    logic        faultClear;
    logic        crcFault;
    logic        linkActive;
    sspr_write_t lastWr;
    logic [7:0]  rx[8];
    logic [7:0]  pkt[8];
    int          nStrobe = 0;
    int          cycles = 0;
    int          error_cnt = 0;
    int          n_checks = 0;

    always #25 clk = ~clk;
    // register file stand-in: a byte derived from its offset
    assign readByte = readOffset ^ 8'h5A;

    sspr_relay DUT (
        .clk, .rst_n, .isBase(1'b1), .deviceAddr, .check_byte_disable,
        .hostSelect_n, .hostSclk, .host_serial_in, .host_serial_out,
        .hostAlert, .southIn('0), .southOut, .northIn, .northOut,
        .readOffset, .readByte, .writeStrobe, .writeData, .faultClear,
        .crcFault, .linkActive
    );
    sspr_host_model host (
        .clk, .hostSelect_n, .hostSclk, .host_serial_in, .host_serial_out
    );

    // ==========================================================
    // commit monitor and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (writeStrobe === 1'b1) begin
            nStrobe <= nStrobe + 1;
            lastWr <= writeData;
        end
        if (cycles == 12000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] b[8], input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++)
            for (int k = 7; k >= 0; k--)
                c = {c[6:0], 1'b0}
                    ^ ((c[7] ^ b[i][k]) ? SSPR_CRC_POLY : 8'h00);
        return c;
    endfunction

    // write of n bytes; bad flips bit 0 of the check byte
    task automatic wr(input logic [5:0] a, input logic [7:0] off,
                      input logic [7:0] dat, input int n, input logic bad);
        logic [7:0] b[8];
        b = '{default: 8'h00};
        b[0] = {1'b0, a, 1'b1};
        b[1] = off;
        b[2] = dat;
        b[3] = crc8(b, 3) ^ {7'h00, bad};
        host.frame(b, n, rx);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        deviceAddr = 6'h05;
        check_byte_disable = 1'b0;
        northIn = '0;
        faultClear = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        wr(6'h05, 8'h21, 8'hC3, 4, 1'b0);
        chk(nStrobe, 1);
        chk(lastWr, {6'h05, 8'h21, 8'hC3});
        chk(crcFault, 1'b0);
        wr(6'h05, 8'h22, 8'h11, 4, 1'b1);
        chk(nStrobe, 1);
        chk(crcFault, 1'b1);
        chk(hostAlert, 1'b1);
        $display("write tests done");
        // read of two bytes; fault cleared while the packet runs
        pkt = '{8'h0A, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        fork
            host.frame(pkt, 6, rx);
            begin
                repeat (60) @(posedge clk);
                faultClear <= 1'b1;
                @(posedge clk);
                faultClear <= 1'b0;
            end
        join
        pkt[3] = 8'h10 ^ 8'h5A;
        pkt[4] = 8'h11 ^ 8'h5A;
        chk(rx[3], pkt[3]);
        chk(rx[4], pkt[4]);
        chk(rx[5], crc8(pkt, 5));
        chk(crcFault, 1'b0);
        $display("read test done");
        // missing check byte, then a good broadcast clears the fault
        wr(6'h05, 8'h23, 8'h44, 3, 1'b0);
        chk(crcFault, 1'b1);
        wr(SSPR_ADDR_BCAST, 8'h30, 8'h5A, 4, 1'b0);
        chk(nStrobe, 2);
        chk(lastWr[15:0], 16'h305A);
        chk(crcFault, 1'b0);
        $display("broadcast test done");
        // foreign address while the upper device replies and alerts
        fork
            wr(6'h07, 8'h40, 8'h01, 4, 1'b0);
            begin
                repeat (8) @(posedge clk);
                northIn <= '{sdo: 1'b1, alert: 1'b1, dataReady: 1'b1,
                             default: 1'b0};
                repeat (200) @(posedge clk);
                chk(hostAlert, 1'b1);
                chk(southOut.dataReady, 1'b1);
                chk(northOut.select, 1'b1);
                chk(linkActive, 1'b1);
                northIn <= '0;
            end
        join
        chk(rx[1], 8'hFF);
        chk(nStrobe, 2);
        $display("relay test done");
        // packets without check byte, then an unaddressed device
        check_byte_disable <= 1'b1;
        wr(6'h05, 8'h31, 8'h77, 3, 1'b0);
        chk(nStrobe, 3);
        chk(lastWr[15:0], 16'h3177);
        check_byte_disable <= 1'b0;
        deviceAddr <= SSPR_ADDR_NONE;
        repeat (5) @(posedge clk);
        fork
            wr(6'h05, 8'h32, 8'h01, 4, 1'b0);
            begin
                repeat (20) @(posedge clk);
                chk(northOut.select, 1'b0);
            end
        join
        chk(nStrobe, 3);
        $display("mode tests done");
        tally_and_finish();
    end
endmodule
